//--- sesq_pkg.sv
// status reporting package: bit positions, thresholds, commands and state
// assumes one 100 MHz clock; measured values arrive already digitised
//
// Functional notes
// - hw faults: link 5, board 4, overvolt 3, overcurrent 2, mains 1, temp 0.
// - overcurrent sets above 62 A.
// - overtemperature sets above 80 C.
// - op: crowbar 6, quench 5, inhibit 4, hot 3, mains 2, ext 1, cal 0.
// - temp high above 75 C; holds ramp and limits compliance.
// - excessive programming voltage refuses external mode and sets bit 1.
// - heater short (below 10 ohm) bit 1, open bit 0.
// - fault triple order: hardware, operational, heater.
// - fault read query returns and clears the fault registers.
// - fault enable masks written by command, read back unchanged.
// - summaries follow the masked event registers without latching.
// - message ready bit 4 set while output buffer holds data.
// - summaries: operation 7, standard 5, hw 2, op 1, heater 0; bit 3 zero.
// - fault summary needs an event bit and its enable.
// - bit 6 set when any summary and its request enable are set.
// - rising edge of bit 6 raises the service request line.
// - serial poll clears the pending request, not the master summary.
// - status byte query returns all eight bits, clears nothing.
// - master summary drops only on source clear or enable cleared.
// - request enable mask written by command, read back, never self-cleared.
// - standard: power-on 7, command 5, execution 4, query 2, complete 0.
// - operation: heater stable 2, ramp done 1, compliance 0; masked summary.
// - clear-status clears all event registers and their summaries.
package sesq_pkg;

    // hardware fault event bits
    localparam int HW_LINK_FAIL = 5;
    localparam int HW_BOARD_FAIL = 4;
    localparam int HW_OVERVOLT = 3;
    localparam int HW_OVERCURRENT = 2;
    localparam int HW_MAINS_LOW = 1;
    localparam int HW_OVERTEMP = 0;

    // operational fault event bits
    localparam int OP_CROWBAR = 6;
    localparam int OP_QUENCH = 5;
    localparam int OP_INHIBIT = 4;
    localparam int OP_TEMP_HIGH = 3;
    localparam int OP_MAINS_HIGH = 2;
    localparam int OP_EXT_PROG = 1;
    localparam int OP_CAL = 0;

    // switch heater fault event bits
    localparam int SH_SHORT = 1;
    localparam int SH_OPEN = 0;

    // status byte positions
    localparam int SB_OPER = 7;
    localparam int SB_MASTER = 6;
    localparam int SB_STD = 5;
    localparam int SB_MSG = 4;
    localparam int SB_UNUSED = 3;
    localparam int SB_HW = 2;
    localparam int SB_OPF = 1;
    localparam int SB_HEAT = 0;

    // thresholds: current in mA, temperature in 0.1 C, load in 0.1 ohm
    localparam logic [15:0] CURRENT_LIMIT_MA = 16'hF230;
    localparam logic [11:0] OVERTEMP_DECI_C = 12'h320;
    localparam logic [11:0] TEMP_HIGH_DECI_C = 12'h2EE;
    localparam logic [15:0] HEATER_SHORT_DECI_OHM = 16'h0064;

    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int REPLY_W = 24;

    typedef enum logic [3:0] {
        SESQ_FAULT_EN_WR,
        SESQ_FAULT_EN_RD,
        SESQ_FAULT_RDCLR,
        SESQ_STD_EN_WR,
        SESQ_STD_EN_RD,
        SESQ_STD_RDCLR,
        SESQ_OPR_EN_WR,
        SESQ_OPR_EN_RD,
        SESQ_OPR_RDCLR,
        SESQ_SRQ_EN_WR,
        SESQ_SRQ_EN_RD,
        SESQ_STB_RD,
        SESQ_CLEAR_STATUS
    } sesq_cmd_kind_t;

    typedef struct packed {
        sesq_cmd_kind_t kind;
        logic [REPLY_W-1:0] data;
    } sesq_cmd_t;

    // discrete fault pins, all asynchronous to sys_clk
    typedef struct packed {
        logic link_fail;
        logic output_board_fail;
        logic output_overvolt;
        logic mains_low;
        logic crowbar_active;
        logic magnet_quench_flag;
        logic remote_inhibit;
        logic mains_high;
        logic cal_bad;
        logic heater_open;
    } sesq_pins_t;

    // standard and operation event pulses from the firmware side
    typedef struct packed {
        logic power_on_flag;
        logic command_fault;
        logic execution_fault;
        logic query_fault;
        logic op_complete_flag;
        logic heater_stable;
        logic ramp_done;
        logic in_compliance;
    } sesq_evt_t;

    typedef struct packed {
        logic [7:0] hw_ev_r;
        logic [7:0] op_ev_r;
        logic [7:0] sh_ev_r;
        logic [7:0] hw_en_r;
        logic [7:0] op_en_r;
        logic [7:0] sh_en_r;
        logic [7:0] std_ev_r;
        logic [7:0] std_en_r;
        logic [7:0] opr_ev_r;
        logic [7:0] opr_en_r;
        logic [7:0] srq_en_r;
        logic [7:0] status_byte_r;
        logic master_prev_r;
        logic request_pending_r;
        logic [REPLY_W-1:0] reply_data_r;
        logic reply_valid_r;
        logic ramp_hold_r;
        logic compliance_limit_r;
        logic ext_prog_granted_r;
    } sesq_state_t;

endpackage

//--- sesq_sync.sv
// two-flop synchroniser for a bundle of asynchronous level inputs
// assumes every bit is a slow level; no bus coherency is kept between bits
`timescale 1ns/1ns
module sesq_sync
#(
    parameter int W = 1
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] stable_r;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            meta_r <= '0;
            stable_r <= '0;
        end
        else if (clk_en)
        begin
            meta_r <= async_in;
            stable_r <= meta_r;
        end
    end

    assign sync_out = stable_r;
endmodule

//--- sesq_status_srq.sv
// fault event registers, status byte and service request generation
// assumes commands and event pulses come from logic on sys_clk, fault
// pins are asynchronous, and measured values are held stable by the adc
`timescale 1ns/1ns
module sesq_status_srq
import sesq_pkg::*;
#(
    parameter int CUR_W = 16,
    parameter int TEMP_W = 12,
    parameter int RES_W = 16,
    parameter int VPROG_W = 16,
    parameter logic [VPROG_W-1:0] PROG_VOLT_LIMIT = 16'h0FFF
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire sesq_pins_t fault_pins,
    input wire logic [CUR_W-1:0] output_current_ma,
    input wire logic [TEMP_W-1:0] internal_temp_deci_c,
    input wire logic [RES_W-1:0] heater_load_deci_ohm,
    input wire logic heater_driven,
    input wire logic ext_prog_request,
    input wire logic [VPROG_W-1:0] prog_voltage,
    input wire sesq_evt_t events_in,
    input wire logic out_buffer_not_empty,
    input wire logic cmd_valid,
    input wire sesq_cmd_t cmd,
    input wire logic serial_poll,
    output logic [REPLY_W-1:0] reply_data,
    output logic reply_valid,
    output logic [7:0] status_byte,
    output logic service_request,
    output logic ramp_hold,
    output logic compliance_limit,
    output logic ext_prog_granted
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisation

    sesq_pins_t pins_s;

    sesq_sync
    #(
        .W($bits(sesq_pins_t))
    )
    u_pin_sync
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .async_in(fault_pins),
        .sync_out(pins_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // fault source conditions

    logic [7:0] hw_src;
    logic [7:0] op_src;
    logic [7:0] sh_src;
    logic [7:0] std_src;
    logic [7:0] opr_src;
    logic temp_over_high;
    logic prog_too_high;

    always_comb
    begin
        temp_over_high = internal_temp_deci_c > TEMP_HIGH_DECI_C;
        prog_too_high = prog_voltage > PROG_VOLT_LIMIT;

        hw_src = BYTE_ZERO;
        hw_src[HW_LINK_FAIL] = pins_s.link_fail;
        hw_src[HW_BOARD_FAIL] = pins_s.output_board_fail;
        hw_src[HW_OVERVOLT] = pins_s.output_overvolt;
        hw_src[HW_OVERCURRENT] = output_current_ma > CURRENT_LIMIT_MA;
        hw_src[HW_MAINS_LOW] = pins_s.mains_low;
        hw_src[HW_OVERTEMP] = internal_temp_deci_c > OVERTEMP_DECI_C;

        op_src = BYTE_ZERO;
        op_src[OP_CROWBAR] = pins_s.crowbar_active;
        op_src[OP_QUENCH] = pins_s.magnet_quench_flag;
        op_src[OP_INHIBIT] = pins_s.remote_inhibit;
        op_src[OP_TEMP_HIGH] = temp_over_high;
        op_src[OP_MAINS_HIGH] = pins_s.mains_high;
        // a refused entry is flagged, never silently dropped
        op_src[OP_EXT_PROG] = ext_prog_request && prog_too_high;
        op_src[OP_CAL] = pins_s.cal_bad;

        sh_src = BYTE_ZERO;
        // a load is only meaningful while the heater is being driven
        sh_src[SH_SHORT] = heater_driven
            && (heater_load_deci_ohm < HEATER_SHORT_DECI_OHM);
        sh_src[SH_OPEN] = pins_s.heater_open;

        std_src = BYTE_ZERO;
        std_src[7] = events_in.power_on_flag;
        std_src[5] = events_in.command_fault;
        std_src[4] = events_in.execution_fault;
        std_src[2] = events_in.query_fault;
        std_src[0] = events_in.op_complete_flag;

        opr_src = BYTE_ZERO;
        opr_src[2] = events_in.heater_stable;
        opr_src[1] = events_in.ramp_done;
        opr_src[0] = events_in.in_compliance;
    end

    ////////////////////////////////////////////////////////////////////////
    // status byte from current register contents and out_buffer_not_empty

    sesq_state_t st_r;
    sesq_state_t st_nxt;
    logic [7:0] summary;
    logic master;
    logic [7:0] stb_view;

    always_comb
    begin
        summary = BYTE_ZERO;
        // plain or-reduce of events under mask, nothing latched here
        summary[SB_OPER] = |(st_r.opr_ev_r & st_r.opr_en_r);
        summary[SB_STD] = |(st_r.std_ev_r & st_r.std_en_r);
        summary[SB_MSG] = out_buffer_not_empty;
        summary[SB_UNUSED] = 1'b0;
        summary[SB_HW] = |(st_r.hw_ev_r & st_r.hw_en_r);
        summary[SB_OPF] = |(st_r.op_ev_r & st_r.op_en_r);
        summary[SB_HEAT] = |(st_r.sh_ev_r & st_r.sh_en_r);
        // bit 6 of the mask cannot feed itself
        master = |(summary & st_r.srq_en_r
            & ~(8'h01 << SB_MASTER));
        stb_view = summary;
        stb_view[SB_MASTER] = master;
    end

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    logic is_cmd;
    logic clr_all;
    logic clr_fault;
    logic clr_std;
    logic clr_opr;

    always_comb
    begin
        st_nxt = st_r;
        is_cmd = cmd_valid;
        clr_all = is_cmd && (cmd.kind == SESQ_CLEAR_STATUS);
        clr_fault = clr_all
            || (is_cmd && (cmd.kind == SESQ_FAULT_RDCLR));
        clr_std = clr_all || (is_cmd && (cmd.kind == SESQ_STD_RDCLR));
        clr_opr = clr_all || (is_cmd && (cmd.kind == SESQ_OPR_RDCLR));

        // sticky events; a source active during a clear stays set
        st_nxt.hw_ev_r = (clr_fault ? BYTE_ZERO : st_r.hw_ev_r)
            | hw_src;
        st_nxt.op_ev_r = (clr_fault ? BYTE_ZERO : st_r.op_ev_r)
            | op_src;
        st_nxt.sh_ev_r = (clr_fault ? BYTE_ZERO : st_r.sh_ev_r)
            | sh_src;
        st_nxt.std_ev_r = (clr_std ? BYTE_ZERO : st_r.std_ev_r)
            | std_src;
        st_nxt.opr_ev_r = (clr_opr ? BYTE_ZERO : st_r.opr_ev_r)
            | opr_src;

        st_nxt.reply_valid_r = 1'b0;
        st_nxt.reply_data_r = st_r.reply_data_r;

        if (is_cmd)
        begin
            unique case (cmd.kind)
                SESQ_FAULT_EN_WR:
                begin
                    st_nxt.hw_en_r = cmd.data[23:16];
                    st_nxt.op_en_r = cmd.data[15:8];
                    st_nxt.sh_en_r = cmd.data[7:0];
                end
                SESQ_FAULT_EN_RD:
                begin
                    st_nxt.reply_data_r = {st_r.hw_en_r, st_r.op_en_r,
                        st_r.sh_en_r};
                    st_nxt.reply_valid_r = 1'b1;
                end
                SESQ_FAULT_RDCLR:
                begin
                    st_nxt.reply_data_r = {st_r.hw_ev_r, st_r.op_ev_r,
                        st_r.sh_ev_r};
                    st_nxt.reply_valid_r = 1'b1;
                end
                SESQ_STD_EN_WR:
                begin
                    st_nxt.std_en_r = cmd.data[7:0];
                end
                SESQ_STD_EN_RD:
                begin
                    st_nxt.reply_data_r = {16'h0000, st_r.std_en_r};
                    st_nxt.reply_valid_r = 1'b1;
                end
                SESQ_STD_RDCLR:
                begin
                    st_nxt.reply_data_r = {16'h0000, st_r.std_ev_r};
                    st_nxt.reply_valid_r = 1'b1;
                end
                SESQ_OPR_EN_WR:
                begin
                    st_nxt.opr_en_r = cmd.data[7:0];
                end
                SESQ_OPR_EN_RD:
                begin
                    st_nxt.reply_data_r = {16'h0000, st_r.opr_en_r};
                    st_nxt.reply_valid_r = 1'b1;
                end
                SESQ_OPR_RDCLR:
                begin
                    st_nxt.reply_data_r = {16'h0000, st_r.opr_ev_r};
                    st_nxt.reply_valid_r = 1'b1;
                end
                SESQ_SRQ_EN_WR:
                begin
                    // writing zero or a reset is the only way to clear the mask
                    st_nxt.srq_en_r = cmd.data[7:0];
                end
                SESQ_SRQ_EN_RD:
                begin
                    st_nxt.reply_data_r = {16'h0000, st_r.srq_en_r};
                    st_nxt.reply_valid_r = 1'b1;
                end
                SESQ_STB_RD:
                begin
                    // reads the master summary, clears nothing
                    st_nxt.reply_data_r = {16'h0000, stb_view};
                    st_nxt.reply_valid_r = 1'b1;
                end
                SESQ_CLEAR_STATUS: ;
                default: ;
            endcase
        end

        // request service: raised on each rising edge of master summary
        st_nxt.master_prev_r = master;
        if (master && !st_r.master_prev_r)
        begin
            st_nxt.request_pending_r = 1'b1;
        end
        else if (serial_poll)
        begin
            st_nxt.request_pending_r = 1'b0;
        end

        // a poll answers with the request bit in place of the master bit
        if (serial_poll && !(is_cmd && (cmd.kind != SESQ_CLEAR_STATUS)
            && (cmd.kind != SESQ_FAULT_EN_WR)
            && (cmd.kind != SESQ_STD_EN_WR)
            && (cmd.kind != SESQ_OPR_EN_WR)
            && (cmd.kind != SESQ_SRQ_EN_WR)))
        begin
            st_nxt.reply_data_r = {16'h0000, summary[7:7],
                st_r.request_pending_r, summary[5:0]};
            st_nxt.reply_valid_r = 1'b1;
        end

        st_nxt.status_byte_r = stb_view;
        // heating relief follows the temperature-high event bit
        st_nxt.ramp_hold_r = st_nxt.op_ev_r[OP_TEMP_HIGH];
        st_nxt.compliance_limit_r = st_nxt.op_ev_r[OP_TEMP_HIGH];
        st_nxt.ext_prog_granted_r = ext_prog_request
            && !prog_too_high;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else if (clk_en)
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, each straight from the state register

    assign reply_data = st_r.reply_data_r;
    assign reply_valid = st_r.reply_valid_r;
    assign status_byte = st_r.status_byte_r;
    assign service_request = st_r.request_pending_r;
    assign ramp_hold = st_r.ramp_hold_r;
    assign compliance_limit = st_r.compliance_limit_r;
    assign ext_prog_granted = st_r.ext_prog_granted_r;

endmodule

//--- sesq_status_srq_properties.sv
// port checker for the status byte and service request block
// assumes it is bound onto sesq_status_srq with one clock domain
`timescale 1ns/1ns
module sesq_chk
import sesq_pkg::*;
#(
    parameter logic [15:0] PROG_VOLT_LIMIT = 16'h0FFF
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [11:0] internal_temp_deci_c,
    input wire logic ext_prog_request,
    input wire logic [15:0] prog_voltage,
    input wire logic out_buffer_not_empty,
    input wire logic cmd_valid,
    input wire sesq_cmd_t cmd,
    input wire logic serial_poll,
    input wire logic reply_valid,
    input wire logic [7:0] status_byte,
    input wire logic service_request,
    input wire logic ramp_hold,
    input wire logic compliance_limit,
    input wire logic ext_prog_granted
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_unused; status_byte[SB_UNUSED] == 1'b0; endproperty
    a_unused: assert property (p_unused) else $error("bit 3 set");
    property p_rise_req;
        $rose(status_byte[SB_MASTER]) |-> service_request;
    endproperty
    a_rise_req: assert property (p_rise_req) else $error("no request");
    property p_req_src;
        $rose(service_request) |-> status_byte[SB_MASTER];
    endproperty
    a_req_src: assert property (p_req_src) else $error("stray req");
    property p_poll_clr;
        serial_poll && clk_en |=>
            !service_request || $rose(status_byte[SB_MASTER]);
    endproperty
    a_poll_clr: assert property (p_poll_clr) else $error("poll kept");
    // a command one cycle back may still be moving the summary
    property p_poll_mss;
        serial_poll && status_byte[SB_MASTER] && !cmd_valid
            && !$past(cmd_valid) |=> status_byte[SB_MASTER];
    endproperty
    a_poll_mss: assert property (p_poll_mss) else $error("mss lost");
    property p_query_ans;
        cmd_valid && clk_en && cmd.kind inside {SESQ_FAULT_EN_RD,
            SESQ_FAULT_RDCLR, SESQ_STB_RD, SESQ_SRQ_EN_RD,
            SESQ_STD_RDCLR, SESQ_OPR_RDCLR} |=> reply_valid;
    endproperty
    a_query_ans: assert property (p_query_ans) else $error("mute");
    property p_reply_once;
        reply_valid && !cmd_valid && !serial_poll |=> !reply_valid;
    endproperty
    a_reply_once: assert property (p_reply_once) else $error("long");
    property p_temp_hold;
        clk_en && internal_temp_deci_c > TEMP_HIGH_DECI_C |=>
            ramp_hold && compliance_limit;
    endproperty
    a_temp_hold: assert property (p_temp_hold) else $error("no hold");
    property p_prog_ok;
        clk_en && ext_prog_request |=>
            ext_prog_granted == ($past(prog_voltage) <= PROG_VOLT_LIMIT);
    endproperty
    a_prog_ok: assert property (p_prog_ok) else $error("grant");
    sequence s_mav_on; (clk_en && out_buffer_not_empty) [*3]; endsequence
    property p_mav_on; s_mav_on |-> status_byte[SB_MSG]; endproperty
    a_mav_on: assert property (p_mav_on) else $error("mav low");
    property p_mav_off;
        (!out_buffer_not_empty) [*3] |-> !status_byte[SB_MSG];
    endproperty
    a_mav_off: assert property (p_mav_off) else $error("mav high");
    property p_fell_hw;
        $fell(status_byte[SB_HW]) |->
            $past(cmd_valid) || $past(cmd_valid, 2) || $past(cmd_valid, 3);
    endproperty
    a_fell_hw: assert property (p_fell_hw) else $error("hw drop");
    c_req: cover property ($rose(service_request));
    c_poll: cover property (serial_poll && service_request);
    c_rdclr: cover property (cmd_valid && cmd.kind == SESQ_FAULT_RDCLR);
endmodule
bind sesq_status_srq sesq_chk #(.PROG_VOLT_LIMIT(PROG_VOLT_LIMIT)) i_chk (.*);

//--- sesq_ctrl_model.sv
// bus controller model: serial polls the block after a request
// assumes poll_wait is set before poll_en rises
`timescale 1ns/1ns
module sesq_ctrl_model
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic poll_en,
    input wire logic [3:0] poll_wait,
    input wire logic service_request,
    output logic serial_poll
);
    logic [4:0] cnt_r;
    // counter saturates after one poll so a slow drop never polls twice
    always_ff @(posedge sys_clk)
    begin
        serial_poll <= 1'b0;
        if (reset || !poll_en || !service_request)
        begin
            cnt_r <= 5'h00;
        end
        else if (cnt_r != 5'h1F)
        begin
            cnt_r <= cnt_r + 5'h01;
            serial_poll <= (cnt_r == {1'b0, poll_wait});
        end
    end
endmodule

//--- tb.sv
// self-checking bench for the status and service request block
// assumes the controller model owns serial_poll; clk_en is held high
`timescale 1ns/1ns
module tb
    import sesq_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    sesq_pins_t pins = '0;
    logic [15:0] cur = 16'h0000;
    logic [15:0] load = 16'h1000;
    logic [15:0] pv = 16'h0000;
    logic [11:0] temp = 12'h000;
    logic ext_rq = 1'b0;
    logic obuf = 1'b0;
    logic cv = 1'b0;
    logic pe = 1'b0;
    logic [3:0] pw = 4'h0;
    sesq_evt_t ev = '0;
    sesq_cmd_t cmd = '0;
    logic sp;
    logic rv;
    logic sr;
    logic [23:0] rd;
    logic [7:0] sb;
    logic [23:0] r;
    logic [23:0] m;
    logic [31:0] seed = 32'h0001_4B81;
    int err_total = 0;
    int total_checks = 0;

    sesq_status_srq i_dut (.sys_clk(sys_clk), .reset(reset),
        .clk_en(1'b1), .fault_pins(pins), .output_current_ma(cur),
        .internal_temp_deci_c(temp), .heater_load_deci_ohm(load),
        .heater_driven(1'b1), .ext_prog_request(ext_rq),
        .prog_voltage(pv), .events_in(ev), .out_buffer_not_empty(obuf),
        .cmd_valid(cv), .cmd(cmd), .serial_poll(sp), .reply_data(rd),
        .reply_valid(rv), .status_byte(sb), .service_request(sr),
        .ramp_hold(), .compliance_limit(), .ext_prog_granted());
    sesq_ctrl_model i_ctrl (.sys_clk(sys_clk), .reset(reset),
        .poll_en(pe), .poll_wait(pw), .service_request(sr),
        .serial_poll(sp));

    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [23:0] exp_tr(input int c);
        case (c)
        0: return 24'h1 << 16 + HW_LINK_FAIL;
        1: return 24'h1 << 16 + HW_BOARD_FAIL;
        2: return 24'h1 << 16 + HW_OVERVOLT;
        3: return 24'h1 << 16 + HW_OVERCURRENT;
        5: return 24'h1 << 16 + HW_MAINS_LOW;
        6: return (24'h1 << 16 + HW_OVERTEMP) | (24'h1 << 8 + OP_TEMP_HIGH);
        7: return 24'h1 << 8 + OP_TEMP_HIGH;
        9: return 24'h1 << 8 + OP_CROWBAR;
        10: return 24'h1 << 8 + OP_QUENCH;
        11: return 24'h1 << 8 + OP_INHIBIT;
        12: return 24'h1 << 8 + OP_MAINS_HIGH;
        13: return 24'h1 << 8 + OP_EXT_PROG;
        15: return 24'h1 << 8 + OP_CAL;
        16: return 24'h1 << SH_SHORT;
        18: return 24'h1 << SH_OPEN;
        default: return 24'h00_0000;
        endcase
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cmp(input logic [23:0] g, e, input string w);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %0t %s %h exp %h", $time, w, g, e);
        end
    endtask

    task automatic chk_rep(input logic [23:0] g, e);
        cmp(g, e, "reply");
    endtask

    task automatic chk_sb(input logic [7:0] g, e);
        cmp({16'h0000, g}, {16'h0000, e}, "status");
    endtask

    task automatic chk_flag(input logic g, e);
        cmp({23'h00_0000, g}, {23'h00_0000, e}, "request");
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // a missing reply turns into unknowns so it never matches
    task automatic qry(input sesq_cmd_kind_t k,
        input logic [23:0] d = 24'h00_0000);
        @(posedge sys_clk);
        cv <= 1'b1;
        cmd <= '{kind: k, data: d};
        @(posedge sys_clk);
        cv <= 1'b0;
        #1;
        r = (rv === 1'b1) ? rd : 24'hxx_xxxx;
    endtask

    task automatic pulse_ev();
        @(posedge sys_clk);
        ev <= '1;
        @(posedge sys_clk);
        ev <= '0;
    endtask

    // cases 4, 7, 8, 14 and 17 sit exactly on a threshold, whose bit must not fire
    task automatic set_case(input int c, input logic on);
        @(posedge sys_clk);
        case (c)
        0: pins.link_fail <= on;
        1: pins.output_board_fail <= on;
        2: pins.output_overvolt <= on;
        3: cur <= on ? CURRENT_LIMIT_MA + 16'(rnd() % 500) + 16'h0001
            : 16'h0000;
        4: cur <= on ? CURRENT_LIMIT_MA : 16'h0000;
        5: pins.mains_low <= on;
        6: temp <= on ? OVERTEMP_DECI_C + 12'h001 : 12'h000;
        7: temp <= on ? OVERTEMP_DECI_C : 12'h000;
        8: temp <= on ? TEMP_HIGH_DECI_C : 12'h000;
        9: pins.crowbar_active <= on;
        10: pins.magnet_quench_flag <= on;
        11: pins.remote_inhibit <= on;
        12: pins.mains_high <= on;
        13, 14:
        begin
            ext_rq <= on;
            pv <= on ? 16'h0FFF + 16'(14 - c) : 16'h0000;
        end
        15: pins.cal_bad <= on;
        16, 17: load <= on ? HEATER_SHORT_DECI_OHM - 16'(17 - c) : 16'h1000;
        18: pins.heater_open <= on;
        default: ;
        endcase
    endtask

    initial
    begin
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        settle(1);
        chk_sb(sb, 8'h00);
        chk_flag(sr, 1'b0);
        qry(SESQ_FAULT_EN_RD);
        chk_rep(r, 24'h00_0000);
        qry(SESQ_SRQ_EN_RD);
        chk_rep(r, 24'h00_0000);
        qry(SESQ_FAULT_RDCLR);
        chk_rep(r, 24'h00_0000);
        $display("test reset done");
        for (int i = 0; i < 5; i++)
        begin
            m = (i == 4) ? 24'h3F_7F03 : 24'(rnd()) & 24'h3F_7F03;
            qry(SESQ_FAULT_EN_WR, m);
            qry(SESQ_FAULT_EN_RD);
            chk_rep(r, m);
            m = {16'h0000, 8'(rnd()) & 8'hBF};
            qry(SESQ_SRQ_EN_WR, (i == 4) ? 24'h00_0000 : m);
            m = (i == 4) ? 24'h00_0000 : m;
            qry(SESQ_SRQ_EN_RD);
            chk_rep(r, m);
            qry(SESQ_SRQ_EN_RD);
            chk_rep(r, m);
        end
        $display("test masks done");
        for (int c = 0; c < 19; c++)
        begin
            set_case(c, 1'b1);
            settle(5);
            qry(SESQ_FAULT_RDCLR);
            chk_rep(r, exp_tr(c));
            set_case(c, 1'b0);
            settle(4);
            qry(SESQ_FAULT_RDCLR);
            chk_rep(r, exp_tr(c));
            qry(SESQ_FAULT_RDCLR);
            chk_rep(r, 24'h00_0000);
        end
        $display("test fault bits done");
        qry(SESQ_SRQ_EN_WR, 24'h00_0004);
        set_case(0, 1'b1);
        settle(6);
        chk_sb(sb, 8'h44);
        chk_flag(sr, 1'b1);
        qry(SESQ_STB_RD);
        chk_rep(r, 24'h00_0044);
        settle(2);
        chk_sb(sb, 8'h44);
        @(posedge sys_clk);
        pe <= 1'b1;
        pw <= 4'(rnd());
        for (int i = 0; i < 40 && sr !== 1'b0; i++)
        begin
            settle(1);
        end
        chk_flag(sr, 1'b0);
        settle(2);
        chk_sb(sb, 8'h44);
        @(posedge sys_clk);
        pe <= 1'b0;
        set_case(0, 1'b0);
        settle(4);
        qry(SESQ_FAULT_RDCLR);
        chk_rep(r, 24'h20_0000);
        settle(3);
        chk_sb(sb, 8'h00);
        qry(SESQ_SRQ_EN_WR);
        qry(SESQ_FAULT_EN_WR);
        set_case(2, 1'b1);
        settle(6);
        chk_sb(sb, 8'h00);
        qry(SESQ_FAULT_EN_WR, 24'h3F_7F03);
        settle(3);
        chk_sb(sb, 8'h04);
        chk_flag(sr, 1'b0);
        qry(SESQ_SRQ_EN_WR, 24'h00_0004);
        settle(3);
        chk_sb(sb, 8'h44);
        chk_flag(sr, 1'b1);
        qry(SESQ_SRQ_EN_WR);
        settle(3);
        chk_sb(sb, 8'h04);
        set_case(2, 1'b0);
        $display("test request done");
        qry(SESQ_STD_EN_WR, 24'h00_00B5);
        qry(SESQ_OPR_EN_WR, 24'h00_0007);
        qry(SESQ_SRQ_EN_WR, 24'h00_0020);
        pulse_ev();
        settle(4);
        chk_sb(sb, 8'hE4);
        qry(SESQ_STD_RDCLR);
        chk_rep(r, 24'h00_00B5);
        qry(SESQ_OPR_RDCLR);
        chk_rep(r, 24'h00_0007);
        settle(3);
        chk_sb(sb, 8'h04);
        pulse_ev();
        qry(SESQ_CLEAR_STATUS);
        settle(3);
        chk_sb(sb, 8'h00);
        qry(SESQ_STD_RDCLR);
        chk_rep(r, 24'h00_0000);
        $display("test events done");
        @(posedge sys_clk);
        obuf <= 1'b1;
        settle(3);
        chk_sb(sb, 8'h10);
        qry(SESQ_SRQ_EN_WR, 24'h00_0010);
        settle(3);
        chk_sb(sb, 8'h50);
        @(posedge sys_clk);
        obuf <= 1'b0;
        settle(3);
        chk_sb(sb, 8'h00);
        $display("test message ready done");
        tally_and_finish();
    end
endmodule
